// ===== hw/jtpg_buf2.sv
// Two-entry valid/ready buffer for the lane data path
`timescale 1ns/1ps
`default_nettype none
module jtpg_buf2 #(
   parameter int WIDTH = 144
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [0:1];
   logic rd_ptr;
   logic wr_ptr;
   logic [1:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= 2'(count + {1'b0, push} - {1'b0, pop});
      end
   end

   // Storage needs no reset; valid is guarded by count
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ===== hw/jtpg_gen.sv
// Transmit-side test-pattern generator: transport, character, alignment and RPAT
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - 8/12-bit formats use the short pattern
// - 8-bit: lane k sends k, then FF-k
// - 12-bit: five samples F-i,i,1..5 plus tail
// - Only enabled low lanes carry transport patterns
// - 16-bit formats use long pattern, both links
// - Long length K*ceil((M*S+2)/K) frames
// - Frame 0 samples equal converter index plus one
// - Frame 1 samples equal sample index plus one
// - Later frames carry two to N-1
// - Walking control bit per frame, then zero
// - Long pattern starts after alignment, repeats until a sync request
// - Alternating mode sends continuous D21.5
// - Comma mode sends continuous K28.5
// - Repeated mode resends alignment instead of data
// - Sync request restarts code group sync, in repeated mode only
// - RPAT twelve-octet sequence per lane
// - Lane power follows link format only
module jtpg_gen (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire jtpg_pkg::jtpg_sel_type TEST_PATTERN_SELECT,
   input wire jtpg_pkg::jtpg_np_type SAMPLE_WIDTH_NP,
   input wire logic [3:0] LINK_FORMAT_LANES,
   input wire logic [4:0] SAMPLE_BITS_N,
   input wire logic [3:0] CONVERTERS_M,
   input wire logic [3:0] SAMPLES_S,
   input wire logic [5:0] MULTIFRAME_K,
   input wire logic [4:0] OCTETS_F,
   input wire logic CONTROL_BITS_EN,
   input wire logic SYNC_N,
   input wire logic ILAS_DONE,
   input wire logic [jtpg_pkg::DATA_W-1:0] IN_DATA,
   input wire logic [jtpg_pkg::LANES-1:0] IN_K,
   input wire logic IN_VALID,
   output logic IN_READY,
   output logic [jtpg_pkg::DATA_W-1:0] OUT_DATA,
   output logic [jtpg_pkg::LANES-1:0] OUT_K,
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output logic [jtpg_pkg::LANES-1:0] LANE_POWER_EN,
   output logic LINK_ILAS_REPEAT,
   output logic LINK_CGS_REQ
);
   import jtpg_pkg::*;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] long_len(input logic [3:0] m, input logic [3:0] s,
                                           input logic [5:0] k);
      logic [8:0] base;
      logic [8:0] kk;
      base = 9'(m * s) + 9'(LONG_EXTRA_FRAMES);
      kk = (k == 6'h00) ? 9'h001 : {3'h0, k};
      long_len = 8'(((base + kk - 9'h001) / kk) * kk);
   endfunction

   // One octet of a long-pattern lane; samples packed MSB first, 16 bits each
   function automatic logic [7:0] long_octet(input int lane, input logic [4:0] p,
                                             input logic [7:0] frame);
      logic [8:0] g;
      logic [7:0] w;
      logic [3:0] cidx;
      logic [3:0] sidx;
      logic [15:0] val;
      logic [15:0] word;
      logic [15:0] ctl;
      g = 9'(lane * OCTETS_F) + {4'h0, p};
      w = g[8:1];
      cidx = (SAMPLES_S == 4'h0) ? 4'h0 : 4'(w / SAMPLES_S);
      sidx = (SAMPLES_S == 4'h0) ? 4'h0 : 4'(w % SAMPLES_S);
      if (frame == 8'h00) begin
         val = 16'(cidx) + 16'h0001;
      end else if (frame == 8'h01) begin
         val = 16'(sidx) + 16'h0001;
      end else begin
         val = 16'h0001 << (SAMPLE_BITS_N - 5'h01);
      end
      word = val << (5'h10 - SAMPLE_BITS_N);
      ctl = 16'h8000 >> SAMPLE_BITS_N;
      // Walking bit: word index equals frame index only below M*S
      if (CONTROL_BITS_EN && (frame < 8'(CONVERTERS_M * SAMPLES_S)) && (w == frame)) begin
         word = word | ctl;
      end
      long_octet = g[0] ? word[7:0] : word[15:8];
   endfunction

   function automatic logic [7:0] short12_octet(input int lane, input logic [4:0] p);
      logic [63:0] v;
      logic [3:0] i;
      i = 4'(lane);
      v = {SHORT12_TOP - i, i, 4'h1, SHORT12_TOP - i, i, 4'h2,
           SHORT12_TOP - i, i, 4'h3, SHORT12_TOP - i, i, 4'h4,
           SHORT12_TOP - i, i, 4'h5, SHORT12_TAIL};
      short12_octet = v[63 - 8*p[2:0] -: 8];
   endfunction

   // ---------------------------------------------------------------
   // Synchroniser for the receiver's request pin
   // ---------------------------------------------------------------
   logic sync_s1;
   logic sync_s2;
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         sync_s1 <= 1'b1;
         sync_s2 <= 1'b1;
      end else begin
         sync_s1 <= SYNC_N;
         sync_s2 <= sync_s1;
      end
   end
   wire sync_req = ~sync_s2;

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   wire mode_normal = (TEST_PATTERN_SELECT == JTPG_SEL_NORMAL);
   wire mode_tpl = (TEST_PATTERN_SELECT == JTPG_SEL_TRANSPORT);
   wire mode_d215 = (TEST_PATTERN_SELECT == JTPG_SEL_D215);
   wire mode_k285 = (TEST_PATTERN_SELECT == JTPG_SEL_K285);
   wire mode_ilas = (TEST_PATTERN_SELECT == JTPG_SEL_ILAS_REP);
   wire mode_rpat = (TEST_PATTERN_SELECT == JTPG_SEL_RPAT);
   wire np_short = (SAMPLE_WIDTH_NP != JTPG_NP_16);
   wire [7:0] pat_len = long_len(CONVERTERS_M, SAMPLES_S, MULTIFRAME_K);
   wire [4:0] frame_oct = np_short ? ((SAMPLE_WIDTH_NP == JTPG_NP_12) ?
                          5'(SHORT12_OCTETS) : 5'h01) : OCTETS_F;

   assign LINK_ILAS_REPEAT = mode_ilas;
   assign LINK_CGS_REQ = mode_ilas & sync_req;

   // ---------------------------------------------------------------
   // Pattern position
   // ---------------------------------------------------------------
   logic tpl_run;
   logic [7:0] frame;
   logic [4:0] octet;
   logic [3:0] rpat_pos;
   logic buf_in_ready;
   wire gen_push = !mode_normal && buf_in_ready;
   wire frame_end = (octet >= frame_oct - 5'h01);
   wire [7:0] frame_lim = np_short ? ((SAMPLE_WIDTH_NP == JTPG_NP_8) ? 8'h02 : 8'h01)
                          : pat_len;

   always_ff @(posedge CLK_SYS) begin
      if (RST || sync_req || !mode_tpl) begin
         tpl_run <= 1'b0;
      end else if (ILAS_DONE) begin
         tpl_run <= 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST || !tpl_run) begin
         frame <= FRAME_RST;
         octet <= OCTET_RST;
      end else if (gen_push) begin
         octet <= frame_end ? OCTET_RST : 5'(octet + 5'h01);
         if (frame_end) begin
            frame <= (frame >= frame_lim - 8'h01) ? FRAME_RST : 8'(frame + 8'h01);
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST || !mode_rpat) begin
         rpat_pos <= RPAT_RST;
      end else if (gen_push) begin
         rpat_pos <= (rpat_pos == 4'(RPAT_LEN - 1)) ? RPAT_RST : 4'(rpat_pos + 4'h1);
      end
   end

   // ---------------------------------------------------------------
   // Lane data selection
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] gen_data;
   logic [LANES-1:0] gen_k;
   logic [LANES-1:0] lane_on;
   wire [7:0] rpat_octet = RPAT_SEQ[RPAT_LEN*8-1 - 8*rpat_pos -: 8];

   always_comb begin
      int lane;
      lane = 0;
      gen_data = '0;
      gen_k = '0;
      lane_on = '0;
      for (int l = 0; l < LANES; l++) begin
         lane = l % LANES_PER_LINK;
         lane_on[l] = (4'(lane) < LINK_FORMAT_LANES);
         if (mode_normal) begin
            gen_data[8*l +: 8] = IN_DATA[8*l +: 8];
            gen_k[l] = IN_K[l];
         end else if (mode_d215) begin
            gen_data[8*l +: 8] = D21_5;
         end else if (mode_k285) begin
            gen_data[8*l +: 8] = K28_5;
            gen_k[l] = 1'b1;
         end else if (mode_rpat) begin
            gen_data[8*l +: 8] = rpat_octet;
         end else if (mode_tpl && tpl_run && lane_on[l]) begin
            if (SAMPLE_WIDTH_NP == JTPG_NP_8) begin
               gen_data[8*l +: 8] = (frame == 8'h00) ? SHORT8_BASE + 8'(lane)
                                    : SHORT8_TOP - 8'(lane);
            end else if (SAMPLE_WIDTH_NP == JTPG_NP_12) begin
               gen_data[8*l +: 8] = short12_octet(lane, octet);
            end else begin
               gen_data[8*l +: 8] = long_octet(lane, octet, frame);
            end
         end
      end
   end

   // Lane power follows the link format, never the test choice
   assign LANE_POWER_EN = lane_on;

   // ---------------------------------------------------------------
   // Output buffer
   // ---------------------------------------------------------------
   // One source at a time: the input is only accepted in normal mode
   wire buf_in_valid = mode_normal ? IN_VALID : 1'b1;
   assign IN_READY = mode_normal & buf_in_ready;

   logic [DATA_W+LANES-1:0] buf_out;
   jtpg_buf2 #(
      .WIDTH(DATA_W + LANES)
   ) u_buf (
      .clk(CLK_SYS),
      .rst(RST),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data({gen_k, gen_data}),
      .out_valid(OUT_VALID),
      .out_ready(OUT_READY),
      .out_data(buf_out)
   );
   assign OUT_DATA = buf_out[DATA_W-1:0];
   assign OUT_K = buf_out[DATA_W+LANES-1:DATA_W];
endmodule
`default_nettype wire

// ===== include/jtpg_pkg.sv
// Shared constants and types for the transmit test-pattern generator
package jtpg_pkg;
   // ---------------------------------------------------------------
   // Lane geometry
   // ---------------------------------------------------------------
   localparam int LANES_PER_LINK = 8;
   localparam int LINKS = 2;
   localparam int LANES = LANES_PER_LINK * LINKS;
   localparam int DATA_W = LANES * 8;

   // ---------------------------------------------------------------
   // Test selection and sample formats
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      JTPG_SEL_NORMAL    = 3'h0,
      JTPG_SEL_TRANSPORT = 3'h1,
      JTPG_SEL_D215      = 3'h2,
      JTPG_SEL_K285      = 3'h3,
      JTPG_SEL_ILAS_REP  = 3'h4,
      JTPG_SEL_RPAT      = 3'h5
   } jtpg_sel_type;

   typedef enum logic [1:0] {
      JTPG_NP_8  = 2'h0,
      JTPG_NP_12 = 2'h1,
      JTPG_NP_16 = 2'h2
   } jtpg_np_type;

   // ---------------------------------------------------------------
   // Character and pattern values
   // ---------------------------------------------------------------
   localparam logic [7:0] D21_5 = 8'hB5;
   localparam logic [7:0] K28_5 = 8'hBC;
   localparam logic [7:0] SHORT8_BASE = 8'h00;
   localparam logic [7:0] SHORT8_TOP = 8'hFF;
   localparam logic [3:0] SHORT12_TOP = 4'hF;
   localparam logic [3:0] SHORT12_TAIL = 4'h0;
   localparam int SHORT12_OCTETS = 8;
   localparam int RPAT_LEN = 12;
   localparam logic [RPAT_LEN*8-1:0] RPAT_SEQ =
      96'hBE_D7_23_47_6B_8F_B3_14_5E_FB_35_59;
   localparam int LONG_EXTRA_FRAMES = 2;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] FRAME_RST = 8'h00;
   localparam logic [4:0] OCTET_RST = 5'h00;
   localparam logic [3:0] RPAT_RST = 4'h0;
endpackage

// ===== sim/jtpg_gen_chk.sv
// Port-level checks for the test-pattern generator
`timescale 1ns/1ps
`default_nettype none
module jtpg_gen_chk (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire jtpg_pkg::jtpg_sel_type TEST_PATTERN_SELECT,
   input wire logic [3:0] LINK_FORMAT_LANES,
   input wire logic SYNC_N,
   input wire logic [jtpg_pkg::DATA_W-1:0] OUT_DATA,
   input wire logic [jtpg_pkg::LANES-1:0] OUT_K,
   input wire logic OUT_VALID,
   input wire logic OUT_READY,
   input wire logic IN_READY,
   input wire logic [jtpg_pkg::LANES-1:0] LANE_POWER_EN,
   input wire logic LINK_ILAS_REPEAT,
   input wire logic LINK_CGS_REQ
);
   import jtpg_pkg::*;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   wire [7:0] pw = 8'((9'h001 << LINK_FORMAT_LANES) - 9'h001);
   wire rep = TEST_PATTERN_SELECT == JTPG_SEL_ILAS_REP;
   sequence s_sync_low;
      (rep && !SYNC_N)[*3];
   endsequence
   sequence s_sync_high;
      SYNC_N[*4];
   endsequence
   AST_K285: assert property (TEST_PATTERN_SELECT == JTPG_SEL_K285 && OUT_VALID
      && $past(TEST_PATTERN_SELECT, 2) == JTPG_SEL_K285
      |-> OUT_DATA == {LANES{K28_5}} && OUT_K == {LANES{1'b1}}) else $error("comma stream wrong");
   AST_D215: assert property (TEST_PATTERN_SELECT == JTPG_SEL_D215 && OUT_VALID
      && $past(TEST_PATTERN_SELECT, 2) == JTPG_SEL_D215
      |-> OUT_DATA == {LANES{D21_5}} && OUT_K == '0) else $error("alternating stream wrong");
   AST_POWER: assert property (LANE_POWER_EN == {pw, pw})
      else $error("lane power wrong");
   AST_REPEAT: assert property (LINK_ILAS_REPEAT == rep)
      else $error("alignment repeat wrong");
   AST_CGS: assert property (s_sync_low |-> LINK_CGS_REQ)
      else $error("sync request not passed on");
   AST_CGS_DROP: assert property (s_sync_high |-> !LINK_CGS_REQ)
      else $error("sync request held too long");
   AST_CGS_MODE: assert property (LINK_CGS_REQ |-> rep)
      else $error("sync restart outside repeat mode");
   AST_IN_READY: assert property (IN_READY |-> TEST_PATTERN_SELECT == JTPG_SEL_NORMAL)
      else $error("input taken in test mode");
   AST_HOLD: assert property (OUT_VALID && !OUT_READY
      |=> OUT_VALID && $stable(OUT_DATA) && $stable(OUT_K)) else $error("word lost in stall");
endmodule
bind jtpg_gen jtpg_gen_chk i_chk (.CLK_SYS, .RST, .TEST_PATTERN_SELECT, .LINK_FORMAT_LANES,
   .SYNC_N, .OUT_DATA, .OUT_K, .OUT_VALID, .OUT_READY, .IN_READY, .LANE_POWER_EN,
   .LINK_ILAS_REPEAT, .LINK_CGS_REQ);
`default_nettype wire

// ===== sim/jtpg_gen_test.sv
// Self-checking bench for the test-pattern generator
`timescale 1ns/1ps
`default_nettype none
module jtpg_gen_test;
   import jtpg_pkg::*;
   localparam int W = DATA_W + LANES;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic ilas_done = 1'b0;
   logic in_valid = 1'b0;
   logic took = 1'b0;
   logic hold = 1'b0;
   logic sync_req = 1'b0;
   logic cs = 1'b0;
   logic [3:0] lanes = 4'h4;
   logic [DATA_W-1:0] in_data = '0;
   logic [LANES-1:0] in_k = '0;
   jtpg_sel_type sel = JTPG_SEL_NORMAL;
   jtpg_np_type np = JTPG_NP_8;
   wire sync_n, in_ready, out_valid, out_ready, ilas_rep, cgs_req;
   wire [DATA_W-1:0] out_data;
   wire [LANES-1:0] out_k, power;
   logic [W-1:0] exp_q[$];
   logic [W-1:0] want;
   integer errors = 0, checks = 0, k = 0, cyc = 0, seed = 32'h556a;
   initial forever #10 clk_sys = ~clk_sys;
   jtpg_gen i_dut (.CLK_SYS(clk_sys), .RST(rst), .TEST_PATTERN_SELECT(sel),
      .SAMPLE_WIDTH_NP(np), .LINK_FORMAT_LANES(lanes), .SAMPLE_BITS_N(5'h10),
      .CONVERTERS_M(4'h2), .SAMPLES_S(4'h1), .MULTIFRAME_K(6'h0A), .OCTETS_F(5'h01),
      .CONTROL_BITS_EN(cs), .SYNC_N(sync_n), .ILAS_DONE(ilas_done), .IN_DATA(in_data),
      .IN_K(in_k), .IN_VALID(in_valid), .IN_READY(in_ready), .OUT_DATA(out_data),
      .OUT_K(out_k), .OUT_VALID(out_valid), .OUT_READY(out_ready), .LANE_POWER_EN(power),
      .LINK_ILAS_REPEAT(ilas_rep), .LINK_CGS_REQ(cgs_req));
   jtpg_rx_model i_rx (.clk(clk_sys), .hold(hold), .sync_req(sync_req), .ready(out_ready),
      .sync_n(sync_n));
   task automatic wrap_up();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [W-1:0] e, input logic [W-1:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   // Long pattern with the tied format: K=10, M=2, S=1, N=16, F=1
   localparam int LONG_LEN = 10 * ((2 * 1 + 2 + 10 - 1) / 10);
   function automatic logic [7:0] tpl_octet(input int j, input int m);
      logic [63:0] v;
      logic [15:0] s;
      int f;
      v = '0;
      s = '0;
      f = 0;
      if (np == JTPG_NP_8)
         return (m % 2) ? 8'hFF - 8'(j) : 8'(j);
      if (np == JTPG_NP_12) begin
         for (int q = 0; q < 5; q++)
            v[63-12*q-:12] = {4'(15 - j), 4'(j), 4'(q + 1)};
         return v[63-8*(m%8)-:8];
      end
      f = m % LONG_LEN;
      s = (f == 0) ? 16'(j / 2 + 1) : (f == 1) ? 16'h0001 : 16'h8000;
      return (j % 2) ? s[7:0] : s[15:8];
   endfunction
   function automatic logic [W-1:0] expect_word(input int n);
      logic [DATA_W-1:0] d;
      d = '0;
      for (int l = 0; l < LANES; l++) begin
         case (sel)
            JTPG_SEL_K285: d[8*l+:8] = K28_5;
            JTPG_SEL_D215: d[8*l+:8] = D21_5;
            JTPG_SEL_RPAT: d[8*l+:8] = RPAT_SEQ[8*(RPAT_LEN-1-n%RPAT_LEN)+:8];
            // Two stalled zero words precede the first frame
            default: if (n >= 2 && l % 8 < lanes)
               d[8*l+:8] = tpl_octet(l % 8, n - 2);
         endcase
      end
      return {d, (sel == JTPG_SEL_K285) ? {LANES{1'b1}} : {LANES{1'b0}}};
   endfunction
   // ---------------------------------------------------------------
   // Reference model and stimulus
   // ---------------------------------------------------------------
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         wrap_up();
      end
      took = !rst && in_valid && in_ready;
      if (took)
         exp_q.push_back({in_data, in_k});
      if (!rst && out_valid && out_ready && sel != JTPG_SEL_ILAS_REP) begin
         want = (sel == JTPG_SEL_NORMAL) ? exp_q.pop_front() : expect_word(k);
         chk(want, {out_data, out_k});
         k++;
      end
   end
   // Input word is held until the edge that takes it
   always @(negedge clk_sys) begin
      if (!in_valid || took) begin
         in_valid = sel == JTPG_SEL_NORMAL && !rst && ($random(seed) & 1) != 0;
         in_data = {4{$random(seed)}};
         in_k = 16'($random(seed));
      end
   end
   task automatic run(input jtpg_sel_type m);
      rst = 1'b1;
      sel = m;
      hold = (m == JTPG_SEL_TRANSPORT);
      repeat (8) @(negedge clk_sys);
      exp_q.delete();
      k = 0;
      rst = 1'b0;
      if (hold) begin
         repeat (5) @(negedge clk_sys);
         ilas_done = 1'b1;
         @(negedge clk_sys);
         ilas_done = 1'b0;
         hold = 1'b0;
      end
      repeat (60) @(negedge clk_sys);
      if (m != JTPG_SEL_ILAS_REP)
         chk(W'(1), W'(k >= 20));
   endtask
   initial begin
      run(JTPG_SEL_K285);
      run(JTPG_SEL_D215);
      run(JTPG_SEL_RPAT);
      run(JTPG_SEL_NORMAL);
      run(JTPG_SEL_TRANSPORT);
      lanes = 4'h2;
      run(JTPG_SEL_TRANSPORT);
      np = JTPG_NP_12;
      run(JTPG_SEL_TRANSPORT);
      np = JTPG_NP_16;
      lanes = 4'h4;
      run(JTPG_SEL_TRANSPORT);
      run(JTPG_SEL_ILAS_REP);
      sync_req = 1'b1;
      repeat (5) @(negedge clk_sys);
      chk(W'(2'b11), W'({ilas_rep, cgs_req}));
      sync_req = 1'b0;
      repeat (5) @(negedge clk_sys);
      chk(W'(2'b10), W'({ilas_rep, cgs_req}));
      for (int n = 1; n <= 8; n++) begin
         lanes = 4'(n);
         @(negedge clk_sys);
         chk(W'({2{8'((9'h001 << n) - 9'h001)}}), W'(power));
      end
      wrap_up();
   end
endmodule
`default_nettype wire

// ===== sim/jtpg_rx_model.sv
// Receiver-side model: stalls the output stream and raises sync requests
`timescale 1ns/1ps
`default_nettype none
module jtpg_rx_model (
   input wire logic clk,
   input wire logic hold,
   input wire logic sync_req,
   output logic ready = 1'b0,
   output logic sync_n = 1'b1
);
   integer seed = 32'h556a;
   // Random stalls, so words must stand in the buffer
   always @(negedge clk) begin
      ready <= !hold && (($random(seed) & 3) != 0);
      sync_n <= !sync_req;
   end
endmodule
`default_nettype wire
